// ### opt_mgmt_regs.vh
// Register map, field positions and two-wire constants of the optical module management logic.
`ifndef OPT_MGMT_REGS_VH
`define OPT_MGMT_REGS_VH

// ****************************************************************
// Two-wire device addresses (seven-bit form)
// ****************************************************************
`define DEV_ADDR_ID      7'h50
`define DEV_ADDR_DIAG    7'h51

// ****************************************************************
// Diagnostics page layout
// ****************************************************************
`define DIAG_TEMP_HI     8'h60
`define DIAG_TEMP_LO     8'h61
`define DIAG_VCC_HI      8'h62
`define DIAG_VCC_LO      8'h63
`define DIAG_BIAS_HI     8'h64
`define DIAG_BIAS_LO     8'h65
`define DIAG_TXPWR_HI    8'h66
`define DIAG_TXPWR_LO    8'h67
`define DIAG_RXPWR_HI    8'h68
`define DIAG_RXPWR_LO    8'h69
`define MODULE_CONTROL_STATUS 8'h6E

// ****************************************************************
// Control/status byte fields
// ****************************************************************
`define CS_LIGHT_LOST    1
`define CS_TX_FAULT      2
`define CS_SOFT_RATE     3
`define CS_RATE_STATE    4
`define CS_SOFT_TXDIS    6
`define CS_TXDIS_STATE   7
`define CS_RESET         8'h00

// ****************************************************************
// Serial engine counts
// ****************************************************************
`define BIT_LAST         4'h7
`define BIT_ACK          4'h8
`define BIT_FIRST        4'h0

`endif

// ### optical_module_mgmt_ctrl.v
// Management, control and status logic of a pluggable optical transceiver module.
//
// Overview of operation
// - Reads at the identification address return a 256-byte identification page.
// - Accesses at the diagnostics address reach a second 256-byte page.
// - Diagnostics page shows live temperature, supply, bias, transmit and receive power.
// - Laser-off input high shuts the transmitter off; low lets it run.
// - An undriven laser-off input counts as high until the host drives low.
// - Asserting then releasing laser-off clears the latched fault state.
// - Status byte bit six is software laser-off; bit seven shows the pin.
// - Transmitter is disabled when software bit or laser-off pin is set.
// - A catastrophic laser fault raises the fault output and disables the laser.
// - Fault output is low in normal operation and high on a fault.
// - Fault stays latched until laser-off is toggled or power is cycled.
// - Status byte bit two mirrors the transmitter fault.
// - Unsafe optical output detected by supervision disables the transmitter.
// - Transmitter disable and loss-of-light states are readable over the serial bus.
// - Status byte bit one shows loss of light: high means unusable input.
// - Status byte bit three is software rate choice; bit four shows rate state.
// - Rate choice is software bit OR pin; high selects high rate.
`timescale 1ns/1ps
`default_nettype none
`include "opt_mgmt_regs.vh"

// ****************************************************************
// Input filter: three flops, a change counts once two agree
// ****************************************************************
module in_filter #(
   parameter RESET_LEVEL = 1'b1
) (
   input  wire clk_i,
   input  wire rst_i,
   input  wire pin_i,
   output reg  lvl_o,
   output reg  rise_o,
   output reg  fall_o
);
   reg s1_q, s2_q, s3_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_q   <= RESET_LEVEL;
         s2_q   <= RESET_LEVEL;
         s3_q   <= RESET_LEVEL;
         lvl_o  <= RESET_LEVEL;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         s1_q   <= pin_i;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         rise_o <= (s2_q == s3_q) && s3_q && !lvl_o;
         fall_o <= (s2_q == s3_q) && !s3_q && lvl_o;
         if (s2_q == s3_q) begin
            lvl_o <= s3_q;
         end
      end
   end
endmodule

// ****************************************************************
// Top level
// ****************************************************************
module optical_module_mgmt_ctrl (
   // Clock and reset
   input  wire        CORE_CLK_I,
   input  wire        RST_I,
   // Two-wire serial management bus
   input  wire        SCL_I,
   input  wire        SDA_I,
   output wire        SDA_O,
   output wire        SDA_OE_N_O,
   // Host control pins
   input  wire        TX_DISABLE_I,
   input  wire        RATE_SEL_I,
   output wire        TX_FAULT_O,
   output wire        TX_FAULT_OE_N_O,
   // Module internals
   input  wire        LASER_FAULT_I,
   input  wire        UNSAFE_POWER_I,
   input  wire        INPUT_LIGHT_LOST_I,
   input  wire [15:0] TEMP_I,
   input  wire [15:0] VCC_I,
   input  wire [15:0] BIAS_I,
   input  wire [15:0] TX_POWER_I,
   input  wire [15:0] RX_POWER_I,
   output reg         LASER_EN_O,
   output reg         RATE_HIGH_O,
   // Factory load of the identification page
   input  wire        ID_LOAD_I,
   input  wire [7:0]  ID_LOAD_ADDR_I,
   input  wire [7:0]  ID_LOAD_DATA_I
);
   localparam ST_IDLE = 3'h0;
   localparam ST_DEV  = 3'h1;
   localparam ST_WADR = 3'h2;
   localparam ST_WDAT = 3'h3;
   localparam ST_RD   = 3'h4;

   wire       scl_lvl, scl_rise, scl_fall;
   wire       sda_lvl, sda_rise, sda_fall;
   wire       txdis_lvl, txdis_fall, rate_lvl, lost_lvl, dev_hit;

   reg  [7:0] id_mem [0:255];
   reg  [7:0] diag_mem [0:255];
   reg  [2:0] state_q;
   reg  [3:0] bit_q;
   reg  [7:0] shift_q, out_q, ptr_q;
   reg        page_q, rw_q, nack_q, sda_low_q, primed_q;
   reg        soft_txdis_q, soft_rate_q, fault_q;
   reg  [7:0] status, rd_byte;

   // The laser-off pin resets to high so an undriven pin keeps the laser dark.
   in_filter #(.RESET_LEVEL(1'b1)) u_scl (.clk_i(CORE_CLK_I), .rst_i(RST_I), .pin_i(SCL_I),
      .lvl_o(scl_lvl), .rise_o(scl_rise), .fall_o(scl_fall));
   in_filter #(.RESET_LEVEL(1'b1)) u_sda (.clk_i(CORE_CLK_I), .rst_i(RST_I), .pin_i(SDA_I),
      .lvl_o(sda_lvl), .rise_o(sda_rise), .fall_o(sda_fall));
   in_filter #(.RESET_LEVEL(1'b1)) u_txd (.clk_i(CORE_CLK_I), .rst_i(RST_I), .pin_i(TX_DISABLE_I),
      .lvl_o(txdis_lvl), .rise_o(), .fall_o(txdis_fall));
   in_filter #(.RESET_LEVEL(1'b0)) u_rate (.clk_i(CORE_CLK_I), .rst_i(RST_I), .pin_i(RATE_SEL_I),
      .lvl_o(rate_lvl), .rise_o(), .fall_o());
   in_filter #(.RESET_LEVEL(1'b1)) u_lost (.clk_i(CORE_CLK_I), .rst_i(RST_I),
      .pin_i(INPUT_LIGHT_LOST_I), .lvl_o(lost_lvl), .rise_o(), .fall_o());

   // ****************************************************************
   // Laser control and fault latch
   // ****************************************************************
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         fault_q     <= 1'b0;
         LASER_EN_O  <= 1'b0;
         RATE_HIGH_O <= 1'b0;
      end else begin
         // A fault arriving with the clearing edge wins over the clear.
         if (LASER_FAULT_I || UNSAFE_POWER_I) begin
            fault_q <= 1'b1;
         end else if (txdis_fall) begin
            fault_q <= 1'b0;
         end
         LASER_EN_O  <= !(txdis_lvl || soft_txdis_q || fault_q || LASER_FAULT_I
                          || UNSAFE_POWER_I);
         RATE_HIGH_O <= rate_lvl || soft_rate_q;
      end
   end

   // Open collector: released (pulled high) on a fault, driven low otherwise.
   assign TX_FAULT_O      = 1'b0;
   assign TX_FAULT_OE_N_O = fault_q;

   // ****************************************************************
   // Page memories and read mux
   // ****************************************************************
   always @* begin
      status = `CS_RESET;
      status[`CS_TXDIS_STATE] = txdis_lvl;
      status[`CS_SOFT_TXDIS]  = soft_txdis_q;
      status[`CS_RATE_STATE]  = RATE_HIGH_O;
      status[`CS_SOFT_RATE]   = soft_rate_q;
      status[`CS_TX_FAULT]    = fault_q;
      status[`CS_LIGHT_LOST]  = lost_lvl;
   end

   always @* begin
      if (!page_q) begin
         rd_byte = id_mem[ptr_q];
      end else begin
         case (ptr_q)
            `DIAG_TEMP_HI:          rd_byte = TEMP_I[15:8];
            `DIAG_TEMP_LO:          rd_byte = TEMP_I[7:0];
            `DIAG_VCC_HI:           rd_byte = VCC_I[15:8];
            `DIAG_VCC_LO:           rd_byte = VCC_I[7:0];
            `DIAG_BIAS_HI:          rd_byte = BIAS_I[15:8];
            `DIAG_BIAS_LO:          rd_byte = BIAS_I[7:0];
            `DIAG_TXPWR_HI:         rd_byte = TX_POWER_I[15:8];
            `DIAG_TXPWR_LO:         rd_byte = TX_POWER_I[7:0];
            `DIAG_RXPWR_HI:         rd_byte = RX_POWER_I[15:8];
            `DIAG_RXPWR_LO:         rd_byte = RX_POWER_I[7:0];
            `MODULE_CONTROL_STATUS: rd_byte = status;
            default:                rd_byte = diag_mem[ptr_q];
         endcase
      end
   end

   // The identification page is read-only on the serial bus.
   always @(posedge CORE_CLK_I) begin
      if (ID_LOAD_I) begin
         id_mem[ID_LOAD_ADDR_I] <= ID_LOAD_DATA_I;
      end
   end

   // Live values and the status byte are read from outside the array, so array writes there are never read back.
   always @(posedge CORE_CLK_I) begin
      if (state_q == ST_WDAT && scl_fall && bit_q == `BIT_LAST && page_q) begin
         diag_mem[ptr_q] <= shift_q;
      end
   end

   // ****************************************************************
   // Two-wire serial engine
   // ****************************************************************
   assign dev_hit    = (shift_q[7:1] == `DEV_ADDR_ID) || (shift_q[7:1] == `DEV_ADDR_DIAG);
   assign SDA_O      = 1'b0;
   assign SDA_OE_N_O = !sda_low_q;

   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         state_q      <= ST_IDLE;
         bit_q        <= `BIT_FIRST;
         shift_q      <= 8'h00;
         out_q        <= 8'h00;
         ptr_q        <= 8'h00;
         page_q       <= 1'b0;
         rw_q         <= 1'b0;
         nack_q       <= 1'b0;
         sda_low_q    <= 1'b0;
         primed_q     <= 1'b0;
         soft_txdis_q <= 1'b0;
         soft_rate_q  <= 1'b0;
      end else if (sda_fall && scl_lvl) begin
         // Start or repeated start restarts the address phase from any state.
         // The clock fall that closes a start is no bit, so falls wait for a rise.
         state_q   <= ST_DEV;
         bit_q     <= `BIT_FIRST;
         sda_low_q <= 1'b0;
         primed_q  <= 1'b0;
      end else if (sda_rise && scl_lvl) begin
         state_q   <= ST_IDLE;
         sda_low_q <= 1'b0;
      end else if (state_q != ST_IDLE) begin
         if (scl_rise) begin
            primed_q <= 1'b1;
            if (bit_q != `BIT_ACK) begin
               shift_q <= {shift_q[6:0], sda_lvl};
            end else begin
               nack_q <= sda_lvl;
            end
         end else if (scl_fall && primed_q) begin
            if (bit_q == `BIT_LAST) begin
               bit_q <= `BIT_ACK;
               case (state_q)
                  ST_DEV: begin
                     if (dev_hit) begin
                        page_q    <= shift_q[1];
                        rw_q      <= shift_q[0];
                        sda_low_q <= 1'b1;
                     end else begin
                        state_q   <= ST_IDLE;
                     end
                  end
                  ST_WADR: begin
                     ptr_q     <= shift_q;
                     sda_low_q <= 1'b1;
                  end
                  ST_WDAT: begin
                     if (page_q && ptr_q == `MODULE_CONTROL_STATUS) begin
                        soft_txdis_q <= shift_q[`CS_SOFT_TXDIS];
                        soft_rate_q  <= shift_q[`CS_SOFT_RATE];
                     end
                     ptr_q     <= ptr_q + 8'h01;
                     sda_low_q <= 1'b1;
                  end
                  default: sda_low_q <= 1'b0;
               endcase
            end else if (bit_q == `BIT_ACK) begin
               bit_q <= `BIT_FIRST;
               case (state_q)
                  ST_DEV: begin
                     if (rw_q) begin
                        state_q   <= ST_RD;
                        out_q     <= rd_byte;
                        sda_low_q <= !rd_byte[7];
                        ptr_q     <= ptr_q + 8'h01;
                     end else begin
                        state_q   <= ST_WADR;
                        sda_low_q <= 1'b0;
                     end
                  end
                  ST_WADR: begin
                     state_q   <= ST_WDAT;
                     sda_low_q <= 1'b0;
                  end
                  ST_RD: begin
                     if (nack_q) begin
                        state_q   <= ST_IDLE;
                        sda_low_q <= 1'b0;
                     end else begin
                        out_q     <= rd_byte;
                        sda_low_q <= !rd_byte[7];
                        ptr_q     <= ptr_q + 8'h01;
                     end
                  end
                  default: sda_low_q <= 1'b0;
               endcase
            end else begin
               bit_q <= bit_q + 4'h1;
               if (state_q == ST_RD) begin
                  out_q     <= {out_q[6:0], 1'b0};
                  sda_low_q <= !out_q[6];
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### optical_module_mgmt_ctrl_chk.sv
// Port assertions of the optical module management logic.
`timescale 1ns/1ps
`default_nettype none
module optical_module_mgmt_ctrl_chk (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic SCL_I,
   input wire logic SDA_O,
   input wire logic SDA_OE_N_O,
   input wire logic TX_DISABLE_I,
   input wire logic RATE_SEL_I,
   input wire logic TX_FAULT_O,
   input wire logic TX_FAULT_OE_N_O,
   input wire logic LASER_FAULT_I,
   input wire logic UNSAFE_POWER_I,
   input wire logic LASER_EN_O,
   input wire logic RATE_HIGH_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   // ********
   // Properties
   // ********
   property p_fault_set; LASER_FAULT_I |=> TX_FAULT_OE_N_O && !LASER_EN_O; endproperty
   a_fault_set: assert property (p_fault_set) else $error("laser fault not latched");
   property p_unsafe; UNSAFE_POWER_I |=> TX_FAULT_OE_N_O && !LASER_EN_O; endproperty
   a_unsafe: assert property (p_unsafe) else $error("unsafe power left laser on");
   property p_fault_hold; TX_DISABLE_I [*5] ##0 TX_FAULT_OE_N_O |=> TX_FAULT_OE_N_O; endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault cleared early");
   property p_fault_dark; TX_FAULT_OE_N_O |-> !LASER_EN_O; endproperty
   a_fault_dark: assert property (p_fault_dark) else $error("laser on during fault");
   property p_pin_off; TX_DISABLE_I [*5] |=> !LASER_EN_O; endproperty
   a_pin_off: assert property (p_pin_off) else $error("laser on while pin high");
   property p_rate; RATE_SEL_I [*5] |=> RATE_HIGH_O; endproperty
   a_rate: assert property (p_rate) else $error("rate pin ignored");
   property p_drive_low; !SDA_O && !TX_FAULT_O; endproperty
   a_drive_low: assert property (p_drive_low) else $error("open drain value high");
   property p_ack_time; $changed(SDA_OE_N_O) |-> !SCL_I && !$past(SCL_I, 3); endproperty
   a_ack_time: assert property (p_ack_time) else $error("data drive moved in clock high");
   property p_reset;
      disable iff (1'b0) RST_I |=> SDA_OE_N_O && !TX_FAULT_OE_N_O && !LASER_EN_O && !RATE_HIGH_O;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs wrong in reset");
endmodule
bind optical_module_mgmt_ctrl optical_module_mgmt_ctrl_chk u_chk (.CORE_CLK_I, .RST_I, .SCL_I,
   .SDA_O, .SDA_OE_N_O, .TX_DISABLE_I, .RATE_SEL_I, .TX_FAULT_O, .TX_FAULT_OE_N_O,
   .LASER_FAULT_I, .UNSAFE_POWER_I, .LASER_EN_O, .RATE_HIGH_O);
`default_nettype wire

// ### host_model.sv
// Two-wire host that clocks the management bus of the optical module.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_o
);
   // ********
   // Bus phases
   // ********
   initial scl_o = 1'b1;
   initial sda_o = 1'b1;
   // A bit takes eight core clocks, a 400 ns period: six low and two high.
   // The low phase is long because the module answers five clocks after the fall.
   task automatic drive(input logic s, input logic d, input int n);
      scl_o = s;
      sda_o = d;
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic start();
      drive(1'b0, sda_o, 1);
      drive(1'b0, 1'b1, 5);
      drive(1'b1, 1'b1, 4);
      drive(1'b1, 1'b0, 4);
   endtask
   task automatic stop();
      drive(1'b0, sda_o, 1);
      drive(1'b0, 1'b0, 5);
      drive(1'b1, 1'b0, 4);
      drive(1'b1, 1'b1, 4);
   endtask
   // Data changes one clock after the fall, so no false start or stop is seen.
   task automatic bit_x(input logic b, output logic r);
      drive(1'b0, sda_o, 1);
      drive(1'b0, b, 5);
      drive(1'b1, b, 2);
      r = sda_i;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] r,
                       output logic ao);
      for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
      bit_x(ai, ao);
   endtask
endmodule
`default_nettype wire

// ### optical_module_mgmt_ctrl_tb.sv
// Self-checking bench of the optical module management logic.
`timescale 1ns/1ps
`default_nettype none
`include "opt_mgmt_regs.vh"
module optical_module_mgmt_ctrl_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        txdis = 1'b1;
   logic        rate = 1'b0;
   logic        lfault = 1'b0;
   logic        unsafe = 1'b0;
   logic        lost = 1'b1;
   logic        ld = 1'b0;
   logic [7:0]  ld_a = 8'h00;
   logic [7:0]  ld_d = 8'h00;
   logic [15:0] mon [5] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
   logic [7:0]  id_m [256];
   logic [7:0]  pick [3] = '{8'h00, 8'h80, 8'hFF};
   logic [7:0]  wvals [3] = '{8'h40, 8'h08, 8'hB7};
   logic [7:0]  v, rv;
   logic        a;
   wire         scl, h_sda, sda_o, sda_oe_n, f_o, f_oe_n, laser, rate_hi;
   wire         sda = h_sda & (sda_oe_n | sda_o);
   int          mismatches = 0;
   int          comparisons = 0;
   int          soft_tx = 0, soft_rt = 0, flt = 0;
   always #25 clk = ~clk;
   optical_module_mgmt_ctrl DUT (.CORE_CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n), .TX_DISABLE_I(txdis), .RATE_SEL_I(rate),
      .TX_FAULT_O(f_o), .TX_FAULT_OE_N_O(f_oe_n), .LASER_FAULT_I(lfault),
      .UNSAFE_POWER_I(unsafe), .INPUT_LIGHT_LOST_I(lost), .TEMP_I(mon[0]), .VCC_I(mon[1]),
      .BIAS_I(mon[2]), .TX_POWER_I(mon[3]), .RX_POWER_I(mon[4]), .LASER_EN_O(laser),
      .RATE_HIGH_O(rate_hi), .ID_LOAD_I(ld), .ID_LOAD_ADDR_I(ld_a), .ID_LOAD_DATA_I(ld_d));
   host_model h (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(h_sda));
   // ********
   // Helpers
   // ********
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [7:0] exp_cs();
      return {txdis, soft_tx[0], 1'b0, rate | soft_rt[0], soft_rt[0], flt[0], lost, 1'b0};
   endfunction
   task automatic pins();
      chk("laser", {7'h0, laser}, {7'h0, !(txdis | soft_tx[0] | flt[0])});
      chk("fault line", {7'h0, f_oe_n ? 1'b1 : f_o}, {7'h0, flt[0]});
      chk("rate", {7'h0, rate_hi}, {7'h0, rate | soft_rt[0]});
   endtask
   task automatic wr(input logic [6:0] dv, input logic [7:0] ad, input logic [7:0] dt);
      h.start();
      h.xfer({dv, 1'b0}, 1'b1, v, a);
      chk("address ack", {7'h0, a}, 8'h00);
      h.xfer(ad, 1'b1, v, a);
      h.xfer(dt, 1'b1, v, a);
      chk("data ack", {7'h0, a}, 8'h00);
      h.stop();
   endtask
   task automatic rd(input logic [6:0] dv, input logic [7:0] ad, output logic [7:0] r);
      h.start();
      h.xfer({dv, 1'b0}, 1'b1, v, a);
      h.xfer(ad, 1'b1, v, a);
      h.start();
      h.xfer({dv, 1'b1}, 1'b1, v, a);
      chk("read ack", {7'h0, a}, 8'h00);
      h.xfer(8'hFF, 1'b1, r, a);
      h.stop();
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #(40000 * 50);
      mismatches++;
      complete_run();
   end
   initial begin
      v = 8'($urandom(25));
      for (int i = 0; i < 5; i++) mon[i] = 16'($urandom);
      tick(5);
      rst = 1'b0;
      tick(8);
      pins();
      txdis = 1'b0;
      tick(8);
      pins();
      $display("test pins done");
      for (int i = 0; i < 256; i++) begin
         ld = 1'b1;
         ld_a = 8'(i);
         ld_d = 8'($urandom);
         id_m[i] = ld_d;
         tick(1);
      end
      ld = 1'b0;
      wr(`DEV_ADDR_ID, 8'hFF, ~id_m[255]);
      for (int i = 0; i < 3; i++) begin
         rd(`DEV_ADDR_ID, pick[i], rv);
         chk("id byte", rv, id_m[pick[i]]);
      end
      $display("test id page done");
      for (int i = 0; i < 10; i++) begin
         rd(`DEV_ADDR_DIAG, 8'(`DIAG_TEMP_HI + i), rv);
         chk("monitor", rv, i[0] ? mon[i / 2][7:0] : mon[i / 2][15:8]);
      end
      $display("test monitors done");
      for (int k = 0; k < 3; k++) begin
         lost = 1'($urandom);
         rate = 1'($urandom);
         wr(`DEV_ADDR_DIAG, `MODULE_CONTROL_STATUS, wvals[k]);
         soft_tx = wvals[k][`CS_SOFT_TXDIS];
         soft_rt = wvals[k][`CS_SOFT_RATE];
         pins();
         rd(`DEV_ADDR_DIAG, `MODULE_CONTROL_STATUS, rv);
         chk("status", rv, exp_cs());
      end
      $display("test status byte done");
      // Toggles are far closer than the host would space them, to keep the run short.
      for (int k = 0; k < 2; k++) begin
         lfault = (k == 0);
         unsafe = (k == 1);
         tick(1);
         lfault = 1'b0;
         unsafe = 1'b0;
         flt = 1;
         pins();
         rd(`DEV_ADDR_DIAG, `MODULE_CONTROL_STATUS, rv);
         chk("status fault", rv, exp_cs());
         txdis = 1'b1;
         tick(8);
         pins();
         txdis = 1'b0;
         flt = 0;
         tick(8);
         pins();
      end
      $display("test fault done");
      rst = 1'b1;
      tick(5);
      rst = 1'b0;
      soft_tx = 0;
      soft_rt = 0;
      tick(1);
      chk("laser after reset", {7'h0, laser}, 8'h00);
      tick(8);
      pins();
      $display("test second reset done");
      complete_run();
   end
endmodule
`default_nettype wire
